// ==== rtl/swpc_top.sv ====
// Sleep/wake power controller: power modes, domain switches, wake sources, comparator control.
// Assumes an APB master on sys_clk_i; pin, comparator and oscillator inputs are asynchronous.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "swpc_defines.svh"
module swpc_top
	import swpc_pkg::*;
(
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_b_i,
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic [31:0]          pwdata_i,
	output logic      [31:0]          prdata_o,
	output logic                      pready_o,
	output logic                      pslverr_o,
	input  wire logic [`SWPC_NPIN-1:0] general_io_pin_i,
	input  wire logic [1:0]           cmp_out_i,
	input  wire logic                 lf_osc_i,
	input  wire logic                 hf_osc_stable_i,
	input  wire logic                 bb_radio_req_i,
	input  wire logic                 irq_any_i,
	output swpc_pwr_t                 pwr_o,
	output swpc_cmp_ctl_t             cmp_ctl_o,
	output logic                      cmp_irq_o,
	output logic                      cpu_halt_o,
	output logic                      cpu_rst_b_o,
	output logic                      pin_hold_o,
	output logic                      dac_hiz_o,
	output logic                      chip_reset_o
);
	localparam logic [4:0] SETTLE = 5'(`SWPC_SETTLE_CYC - 1);

	// Register index from a byte address; bit 4 flags an unmapped address
	function automatic logic [4:0] swpc_dec(input logic [7:0] a);
		logic [3:0] i;
		i = a[5:2];
		if (a[7:6] != 2'b00 || a[1:0] != 2'b00 || i >= 4'(`SWPC_NREG))
			return 5'h10;
		return {1'b0, i};
	endfunction : swpc_dec

	// Synchronised inputs
	logic [`SWPC_NPIN-1:0] pin_lvl;
	logic [`SWPC_NPIN-1:0] pin_rise;
	logic [`SWPC_NPIN-1:0] pin_fall;
	logic [3:0]            aux_lvl;
	logic [3:0]            aux_rise;
	logic [3:0]            aux_fall;

	// Pin edges are taken from the pad side, ahead of any alternate-function mux
	swpc_edge_det #(.W(`SWPC_NPIN)) u_pins (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.async_i   (general_io_pin_i),
		.lvl_o     (pin_lvl),
		.rise_o    (pin_rise),
		.fall_o    (pin_fall)
	);

	// Comparator outputs, slow oscillator and fast-oscillator stable share one synchroniser
	swpc_edge_det #(.W(4)) u_aux (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.async_i   ({hf_osc_stable_i, lf_osc_i, cmp_out_i}),
		.lvl_o     (aux_lvl),
		.rise_o    (aux_rise),
		.fall_o    (aux_fall)
	);

	// State and software registers
	swpc_state_t              state_r;
	swpc_state_t              state_nxt;
	logic [4:0]               ctrl_r;
	logic [`SWPC_CFG_W-1:0]   cfg_r;
	logic [1:0]               cmp_stat_r;
	logic [`SWPC_NPIN-1:0]    pin_en_r;
	logic [`SWPC_NPIN-1:0]    pin_pol_r;
	logic [1:0]               tmr_run_r;
	logic [`SWPC_NPEND-1:0]   pend_r;
	logic [`SWPC_NPEND-1:0]   cause_r;
	logic                     from_sleep_r;
	logic [4:0]               settle_r;
	logic [31:0]              tmr_cnt [2];
	logic [1:0]               tmr_exp;

	// Bus decode
	// A write lands only at the access edge, never in the setup cycle
	wire [4:0] idx       = swpc_dec(paddr_i);
	wire       hit       = ~idx[4];
	wire       setup     = psel_i & ~penable_i;
	wire       wr        = psel_i & penable_i & pready_o & pwrite_i & hit;
	wire       wr_ctrl   = wr & (idx == 5'(`SWPC_A_CTRL >> 2));
	wire       wr_mode   = wr & (idx == 5'(`SWPC_A_MODE >> 2));
	wire       wr_cfg    = wr & (idx == 5'(`SWPC_A_CMP_CFG >> 2));
	wire       wr_pin_en = wr & (idx == 5'(`SWPC_A_PIN_EN >> 2));
	wire       wr_pol    = wr & (idx == 5'(`SWPC_A_PIN_POL >> 2));
	wire       wr_t0     = wr & (idx == 5'(`SWPC_A_TMR0 >> 2));
	wire       wr_t1     = wr & (idx == 5'(`SWPC_A_TMR1 >> 2));
	wire       wr_run    = wr & (idx == 5'(`SWPC_A_TMR_RUN >> 2));
	wire       wr_pend   = wr & (idx == 5'(`SWPC_A_PEND >> 2));
	wire       wr_cause  = wr & (idx == 5'(`SWPC_A_CAUSE >> 2));

	// Mode view
	wire awake  = (state_r == SWPC_ACTIVE) | (state_r == SWPC_DOZE);
	wire asleep = (state_r == SWPC_SLEEP);
	wire deep   = (state_r == SWPC_DEEP);

	// Counts down only in the power-up wait and parks at zero
	wire settle_dec = (state_r == SWPC_PWRUP) & (settle_r != 5'h00);

	// Comparator configuration fields
	wire [1:0] cmp_en   = cfg_r[`SWPC_CFG_EN +: 2];
	wire [1:0] cmp_ien  = cfg_r[`SWPC_CFG_IEN +: 2];
	wire [1:0] cmp_wen  = cfg_r[`SWPC_CFG_WEN +: 2];
	wire [1:0] cmp_rise = cfg_r[`SWPC_CFG_RISE +: 2];

	// The slow oscillator stops in deep sleep, and in sleep unless kept on
	wire lfo_on  = ~deep & (~asleep | ctrl_r[`SWPC_CTRL_LFO]);
	wire tmr_on  = ~deep & (~asleep | ctrl_r[`SWPC_CTRL_TMR]);
	wire lf_tick = aux_rise[2] & lfo_on & tmr_on;

	// Comparator events need the slow oscillator while asleep
	wire [1:0] cmp_ok  = cmp_en & {2{lfo_on}};
	wire [1:0] cmp_edg = (cmp_rise & aux_rise[1:0]) | (~cmp_rise & aux_fall[1:0]);
	wire [1:0] cmp_ev  = cmp_ok & cmp_edg & (cmp_ien | cmp_wen);

	// Pin edges stay live in every mode
	// Polarity one selects the rising edge, zero the falling edge
	wire [`SWPC_NPIN-1:0] pin_ev = pin_en_r & ((pin_pol_r & pin_rise) | (~pin_pol_r & pin_fall));

	wire [`SWPC_NPEND-1:0] pend_set = {cmp_ev, tmr_exp & tmr_run_r, pin_ev};
	wire [`SWPC_NPEND-1:0] pend_clr = wr_pend ? pwdata_i[`SWPC_NPEND-1:0] : '0;
	// A new event wins over a clear in the same cycle
	wire [`SWPC_NPEND-1:0] pend_nxt = (pend_r & ~pend_clr) | pend_set;

	// Comparator events may end sleep only with their wake enable; timer and pin events always may
	wire [`SWPC_NPEND-1:0] wake_mask = {cmp_wen, 2'b11, {`SWPC_NPIN{1'b1}}};
	wire                   wake_req  = |(pend_r & wake_mask);
	wire                   cmp_irq   = |(pend_r[`SWPC_PEND_CMP +: 2] & cmp_ien);

	// Power-mode sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SWPC_ACTIVE: begin
				if (wr_mode) begin
					case (pwdata_i[1:0])
						`SWPC_CMD_DOZE:  state_nxt = SWPC_DOZE;
						`SWPC_CMD_SLEEP: state_nxt = SWPC_SLEEP;
						`SWPC_CMD_DEEP:  state_nxt = SWPC_DEEP;
						default:         state_nxt = SWPC_ACTIVE;
					endcase
				end
			end
			SWPC_DOZE: begin
				// All domains stay up; only the processor stops
				if (irq_any_i || cmp_irq)
					state_nxt = SWPC_ACTIVE;
			end
			SWPC_SLEEP: begin
				// Leftover pending events bring the chip straight back up
				if (wake_req)
					state_nxt = SWPC_OSC;
			end
			SWPC_DEEP: begin
				// Timers and comparators are frozen, so only a pin edge leaves
				if (|pin_ev)
					state_nxt = SWPC_OSC;
			end
			SWPC_OSC: begin
				// Logic power waits for the fast oscillator to report stable; RAM, wake timer and slow oscillator are already on
				if (aux_lvl[3])
					state_nxt = SWPC_PWRUP;
			end
			SWPC_PWRUP: begin
				if (settle_r == 5'h00)
					state_nxt = SWPC_RSTREL;
			end
			SWPC_RSTREL: state_nxt = SWPC_ACTIVE;
			default:     state_nxt = SWPC_ACTIVE;
		endcase
	end

	// Output values for the coming state, registered below
	wire awake_n  = (state_nxt == SWPC_ACTIVE) | (state_nxt == SWPC_DOZE);
	wire sleep_n  = (state_nxt == SWPC_SLEEP);
	wire deep_n   = (state_nxt == SWPC_DEEP);
	wire dig_n    = awake_n | (state_nxt == SWPC_PWRUP) | (state_nxt == SWPC_RSTREL);

	swpc_pwr_t pwr_nxt;
	assign pwr_nxt.dig      = dig_n;
	assign pwr_nxt.ana      = awake_n & ctrl_r[`SWPC_CTRL_ANA];
	assign pwr_nxt.ram      = ~deep_n & (~sleep_n | ctrl_r[`SWPC_CTRL_RAM]);
	assign pwr_nxt.radio    = awake_n & bb_radio_req_i;
	assign pwr_nxt.wake_tmr = ~deep_n & (~sleep_n | ctrl_r[`SWPC_CTRL_TMR]);
	assign pwr_nxt.lfo      = ~deep_n & (~sleep_n | ctrl_r[`SWPC_CTRL_LFO]);
	// The fast oscillator restarts as soon as sleep ends
	assign pwr_nxt.hfo      = ~sleep_n & ~deep_n;

	// Sleep overrides the negative input; the software choice returns on wake
	swpc_cmp_ctl_t cmp_nxt;
	assign cmp_nxt.hyst       = cfg_r[`SWPC_CFG_HYST +: 2];
	assign cmp_nxt.neg_first  = sleep_n ? SWPC_NEG_PIN : swpc_neg_t'(cfg_r[`SWPC_CFG_NEG1 +: 2]);
	assign cmp_nxt.neg_second = sleep_n ? SWPC_NEG_PIN : swpc_neg_t'(cfg_r[`SWPC_CFG_NEG2 +: 2]);
	assign cmp_nxt.en         = cmp_en & {2{~deep_n}};
	assign cmp_nxt.low_pwr    = cfg_r[`SWPC_CFG_LP];

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			state_r      <= SWPC_ACTIVE;
			pwr_o        <= '{dig: 1'b1, ram: 1'b1, wake_tmr: 1'b1, lfo: 1'b1, hfo: 1'b1, default: 1'b0};
			cmp_ctl_o    <= '0;
			cmp_irq_o    <= 1'b0;
			cpu_halt_o   <= 1'b0;
			cpu_rst_b_o  <= 1'b1;
			pin_hold_o   <= 1'b0;
			dac_hiz_o    <= 1'b0;
			chip_reset_o <= 1'b0;
			settle_r     <= 5'h00;
		end else begin
			state_r      <= state_nxt;
			pwr_o        <= pwr_nxt;
			cmp_ctl_o    <= cmp_nxt;
			cmp_irq_o    <= cmp_irq & awake;
			cpu_halt_o   <= (state_nxt == SWPC_DOZE);
			cpu_rst_b_o  <= awake_n;
			pin_hold_o   <= ~dig_n;
			dac_hiz_o    <= ~awake_n;
			chip_reset_o <= deep & (|pin_ev);
			// Power settles for a fixed time before reset release
			settle_r     <= (state_r == SWPC_OSC) ? SETTLE : settle_r - {4'h0, settle_dec};
		end
	end

	// Software registers
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			ctrl_r    <= `SWPC_CTRL_RST;
			cfg_r     <= `SWPC_CFG_RST;
			pin_en_r  <= '0;
			pin_pol_r <= '0;
			tmr_run_r <= 2'b00;
			pend_r    <= '0;
		end else begin
			if (wr_ctrl)
				ctrl_r <= pwdata_i[4:0];
			if (wr_cfg)
				cfg_r <= pwdata_i[`SWPC_CFG_W-1:0];
			if (wr_pin_en)
				pin_en_r <= pwdata_i[`SWPC_NPIN-1:0];
			if (wr_pol)
				pin_pol_r <= pwdata_i[`SWPC_NPIN-1:0];
			if (wr_run)
				tmr_run_r <= pwdata_i[1:0];
			pend_r <= pend_nxt;
		end
	end

	// A disabled comparator freezes its status bit
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i)
			cmp_stat_r <= 2'b00;
		else
			cmp_stat_r <= (cmp_en & aux_lvl[1:0]) | (~cmp_en & cmp_stat_r);
	end

	// Wake cause, cleared by writing ones
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			cause_r      <= '0;
			from_sleep_r <= 1'b0;
		end else if (asleep && state_nxt == SWPC_OSC) begin
			cause_r      <= pend_r & wake_mask;
			from_sleep_r <= 1'b1;
		end else if (deep && state_nxt == SWPC_OSC) begin
			// Deep-sleep exit counts as a full chip reset
			cause_r      <= {{(`SWPC_NPEND - `SWPC_NPIN){1'b0}}, pin_ev};
			from_sleep_r <= 1'b0;
		end else if (wr_cause) begin
			cause_r      <= cause_r & ~pwdata_i[`SWPC_NPEND-1:0];
			from_sleep_r <= from_sleep_r & ~pwdata_i[`SWPC_CAUSE_SLEEP];
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tmr
			swpc_wake_tmr u_tmr (
				.sys_clk_i  (sys_clk_i),
				.rst_b_i    (rst_b_i),
				.load_i     (g == 0 ? wr_t0 : wr_t1),
				.load_val_i (pwdata_i),
				.run_i      (tmr_run_r[g]),
				.tick_i     (lf_tick),
				.cnt_o      (tmr_cnt[g]),
				.expire_o   (tmr_exp[g])
			);
		end
	endgenerate

	// Read mux
	// Reads have no side effect; pending bits clear only on a write of ones, cause bits on a write of ones or a reload at wake
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		case (idx)
			5'(`SWPC_A_CTRL >> 2):     rd_val = {27'h0, ctrl_r};
			5'(`SWPC_A_MODE >> 2):     rd_val = {29'h0, state_r};
			5'(`SWPC_A_CMP_CFG >> 2):  rd_val = {17'h0, cfg_r};
			5'(`SWPC_A_CMP_STAT >> 2): rd_val = {30'h0, cmp_stat_r};
			5'(`SWPC_A_PIN_EN >> 2):   rd_val = {11'h0, pin_en_r};
			5'(`SWPC_A_PIN_POL >> 2):  rd_val = {11'h0, pin_pol_r};
			5'(`SWPC_A_TMR0 >> 2):     rd_val = tmr_cnt[0];
			5'(`SWPC_A_TMR1 >> 2):     rd_val = tmr_cnt[1];
			5'(`SWPC_A_TMR_RUN >> 2):  rd_val = {30'h0, tmr_run_r};
			5'(`SWPC_A_PEND >> 2):     rd_val = {7'h0, pend_r};
			5'(`SWPC_A_CAUSE >> 2):    rd_val = {from_sleep_r, 6'h0, cause_r};
			default:                   rd_val = 32'h0000_0000;
		endcase
	end

	// Zero-wait slave: answer is captured in the setup cycle
	// Unmapped addresses answer with an error and read as zero
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= 1'b1;
			if (setup) begin
				prdata_o  <= hit ? rd_val : 32'h0000_0000;
				pslverr_o <= ~hit;
			end
		end
	end

endmodule : swpc_top
`default_nettype wire

// ==== rtl/swpc_defines.svh ====
// Offsets, field positions, reset values and timing counts of the power controller.
// Assumes a 25 MHz system clock and byte addresses on an 8-bit APB address.
//
// Contract
// - One shared hysteresis: 0, 5, 10, 20mV
// - Per comparator negative input: vref, converter, pin
// - Comparator output polled; interrupt under enable
// - Disabled comparator gives no status or event; here its status bit holds its last value
// - Low-power comparator mode, active or asleep
// - Comparator wake enable and edge select
// - Sleep forces negative inputs to external pin
// - Always-on domain; timers, lfo switchable for sleep
// - Digital domain off in sleep
// - Analogue off in sleep, software switched when active
// - RAM kept in sleep only if retention chosen
// - Radio powered by baseband request only
// - Doze halts processor; any interrupt resumes
// - Sleep holds pins, converter outputs high impedance
// - Oscillator off leaves only pin wakeup
// - Sleep wakes on any enabled source
// - Pending wakes persist; software clears them
// - Oscillator stable, then power, then reset release
// - Two 32-bit wakeup counters on slow clock
// - Per-pin wake enable and edge polarity
// - Pin wake works under alternate functions
// - Deep sleep: all off, pin event resets chip
`ifndef SWPC_DEFINES_SVH
`define SWPC_DEFINES_SVH

`define SWPC_NPIN        21
`define SWPC_NPEND       25

`define SWPC_A_CTRL      8'h00
`define SWPC_A_MODE      8'h04
`define SWPC_A_CMP_CFG   8'h08
`define SWPC_A_CMP_STAT  8'h0c
`define SWPC_A_PIN_EN    8'h10
`define SWPC_A_PIN_POL   8'h14
`define SWPC_A_TMR0      8'h18
`define SWPC_A_TMR1      8'h1c
`define SWPC_A_TMR_RUN   8'h20
`define SWPC_A_PEND      8'h24
`define SWPC_A_CAUSE     8'h28
`define SWPC_NREG        11

`define SWPC_CTRL_ANA    0
`define SWPC_CTRL_RAM    1
`define SWPC_CTRL_LFO    2
`define SWPC_CTRL_TMR    3
`define SWPC_CTRL_RST    5'h00

`define SWPC_CMD_DOZE    2'h1
`define SWPC_CMD_SLEEP   2'h2
`define SWPC_CMD_DEEP    2'h3

`define SWPC_CFG_HYST    0
`define SWPC_CFG_NEG1    2
`define SWPC_CFG_NEG2    4
`define SWPC_CFG_EN      6
`define SWPC_CFG_LP      8
`define SWPC_CFG_IEN     9
`define SWPC_CFG_WEN     11
`define SWPC_CFG_RISE    13
`define SWPC_CFG_W       15
`define SWPC_CFG_RST     15'h0000

`define SWPC_PEND_TMR    21
`define SWPC_PEND_CMP    23
`define SWPC_CAUSE_SLEEP 31

`define SWPC_CLK_NS      40
`define SWPC_SETTLE_NS   1000
`define SWPC_SETTLE_CYC  ((`SWPC_SETTLE_NS + `SWPC_CLK_NS - 1) / `SWPC_CLK_NS)

`endif

// ==== rtl/swpc_pkg.sv ====
// Types of the sleep/wake power controller.
// Assumes the constants of swpc_defines.svh.
package swpc_pkg;

	typedef enum logic [2:0] {
		SWPC_ACTIVE = 3'b000,
		SWPC_DOZE   = 3'b001,
		SWPC_SLEEP  = 3'b010,
		SWPC_DEEP   = 3'b011,
		SWPC_OSC    = 3'b100,
		SWPC_PWRUP  = 3'b101,
		SWPC_RSTREL = 3'b110
	} swpc_state_t;

	typedef enum logic [1:0] {
		SWPC_NEG_VREF = 2'b00,
		SWPC_NEG_DAC  = 2'b01,
		SWPC_NEG_PIN  = 2'b10
	} swpc_neg_t;

	typedef struct packed {
		logic dig;
		logic ana;
		logic ram;
		logic radio;
		logic wake_tmr;
		logic lfo;
		logic hfo;
	} swpc_pwr_t;

	typedef struct packed {
		logic [1:0] hyst;
		swpc_neg_t  neg_first;
		swpc_neg_t  neg_second;
		logic [1:0] en;
		logic       low_pwr;
	} swpc_cmp_ctl_t;

endpackage : swpc_pkg

// ==== rtl/swpc_edge_det.sv ====
// Two-stage synchroniser with edge detection for a group of asynchronous inputs.
// Assumes inputs from outside the sys_clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module swpc_edge_det #(
	parameter int W = 1
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] lvl_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	logic [W-1:0] prev_r;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign lvl_o  = sync_r;
	assign rise_o = sync_r & ~prev_r;
	assign fall_o = ~sync_r & prev_r;
endmodule : swpc_edge_det
`default_nettype wire

// ==== rtl/swpc_wake_tmr.sv ====
// One 32-bit down-counting wakeup timer advanced by slow-clock ticks.
// Assumes tick_i is a one-cycle pulse in the sys_clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module swpc_wake_tmr (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        load_i,
	input  wire logic [31:0] load_val_i,
	input  wire logic        run_i,
	input  wire logic        tick_i,
	output logic      [31:0] cnt_o,
	output logic             expire_o
);
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			cnt_o    <= 32'h0000_0000;
			expire_o <= 1'b0;
		end else begin
			expire_o <= 1'b0;
			if (load_i) begin
				cnt_o <= load_val_i;
			end else if (run_i && tick_i && cnt_o != 32'h0000_0000) begin
				cnt_o    <= cnt_o - 32'h0000_0001;
				expire_o <= (cnt_o == 32'h0000_0001);
			end
		end
	end
endmodule : swpc_wake_tmr
`default_nettype wire

// ==== sim/swpc_checker.sv ====
// Port-level properties of the sleep/wake power controller.
// Assumes it is bound into swpc_top and that everything runs on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module swpc_chk
	import swpc_pkg::*;
(
	input wire logic      sys_clk_i,
	input wire logic      rst_b_i,
	input wire logic      bb_radio_req_i,
	input wire logic      irq_any_i,
	input wire swpc_pwr_t pwr_o,
	input wire logic      cpu_halt_o,
	input wire logic      cpu_rst_b_o,
	input wire logic      pin_hold_o,
	input wire logic      dac_hiz_o,
	input wire logic      chip_reset_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// Wake sequence: logic power comes up while the fast oscillator is on, reset follows
	sequence s_pwr_on;
		$rose(pwr_o.dig) ##0 pwr_o.hfo;
	endsequence
	sequence s_rel;
		##[1:40] $rose(cpu_rst_b_o);
	endsequence

	AST_HOLD: assert property (!pwr_o.dig |-> pin_hold_o && dac_hiz_o)
		else $error("pins or converter outputs not parked");
	AST_OFF: assert property (!pwr_o.dig |-> !pwr_o.ana && !pwr_o.radio)
		else $error("analogue or radio powered with logic off");
	AST_RADIO: assert property ($rose(pwr_o.radio) |-> $past(bb_radio_req_i))
		else $error("radio powered without baseband request");
	AST_SEQ: assert property (s_pwr_on |-> s_rel)
		else $error("processor reset not released after power up");
	AST_ORDER: assert property ($rose(cpu_rst_b_o) |-> $past(pwr_o.dig) && $past(pwr_o.hfo))
		else $error("reset released before power and oscillator");
	AST_CHIPRST: assert property (chip_reset_o |-> !$past(pwr_o.lfo) && !$past(pwr_o.dig) ##1 !chip_reset_o)
		else $error("chip reset outside deep sleep or too long");
	AST_DOZE: assert property (cpu_halt_o && irq_any_i |-> ##[1:2] !cpu_halt_o)
		else $error("doze not ended by interrupt");
	AST_HALT: assert property (cpu_halt_o |-> pwr_o.dig && cpu_rst_b_o)
		else $error("halted processor without power");
endmodule : swpc_chk
`default_nettype wire

// ==== sim/swpc_top_tb.sv ====
// Self-checking bench: APB register traffic, power modes and each kind of wake source.
// Assumes swpc_top with its package and defines; the checker is bound at the foot.
`timescale 1ns/1ps
`default_nettype none
`include "swpc_defines.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
	$display("BAD t=%0t got %h exp %h", $time, a, b); end end
module swpc_top_tb
	import swpc_pkg::*;
;
	logic          clk, rst_b, psel, pen, pwr, hfs, bb, irq;
	logic          lf = 1'b0;
	logic          prdy, perr, cirq, halt, crst_b, hold, hiz, chrst;
	logic [7:0]    paddr;
	logic [31:0]   pwd, prd, rs, cfg;
	logic [20:0]   pins;
	logic [1:0]    cmp;
	logic [2:0]    lfc = 3'h0;
	logic [32:0]   q[$];
	logic [32:0]   ex;
	swpc_pwr_t     pwr_s;
	swpc_cmp_ctl_t ctl_s;
	int            num_errors, cmp_count, i;

	swpc_top u_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
		.general_io_pin_i(pins), .cmp_out_i(cmp), .lf_osc_i(lf), .hf_osc_stable_i(hfs),
		.bb_radio_req_i(bb), .irq_any_i(irq), .pwr_o(pwr_s), .cmp_ctl_o(ctl_s), .cmp_irq_o(cirq),
		.cpu_halt_o(halt), .cpu_rst_b_o(crst_b), .pin_hold_o(hold), .dac_hiz_o(hiz), .chip_reset_o(chrst));

	always #20 clk = ~clk;

	// Slow oscillator sped up to one period per 8 clocks to keep the run short
	always @(posedge clk) begin
		lfc <= lfc + 3'h1;
		lf <= lfc[2];
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic wrap_up();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	// Ends two edges after the access so registered outputs have settled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 16);
		if (n >= 16) begin
			num_errors++;
			wrap_up();
		end
		psel <= 1'b0;
		pen <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	// Waits for the chip reset pulse or for processor reset release
	task automatic wt(input bit chip);
		int n;
		n = 0;
		while ((chip ? chrst : crst_b) !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n >= 400) begin
			num_errors++;
			wrap_up();
		end
	endtask : wt

	always @(posedge clk) begin
		if (psel && pen && prdy === 1'b1 && !pwr) begin
			ex = q.pop_front();
			`CHK({perr, prd}, ex)
		end
	end

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwd = 32'h0;
		pins = 21'h0;
		cmp = 2'b00;
		hfs = 1'b1;
		bb = 1'b0;
		irq = 1'b0;
		rs = 32'ha30a;
		repeat (2) @(posedge clk);
		`CHK(pwr_s, 7'h57)
		rst_b <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 4; i++) begin
			rs = lfsr(rs);
			cfg = {23'h0, rs[8:6], 2'((i + 1) % 3), 2'(i % 3), 2'(i)};
			wr(`SWPC_A_CMP_CFG, cfg);
			`CHK(ctl_s, {cfg[1:0], cfg[3:2], cfg[5:4], cfg[7:6], cfg[8]})
			rd(`SWPC_A_CMP_CFG, {1'b0, cfg});
		end
		rs = lfsr(rs);
		wr(`SWPC_A_PIN_EN, rs);
		rd(`SWPC_A_PIN_EN, {1'b0, rs & 32'h1fffff});
		rd(8'h2c, {1'b1, 32'h0});
		bb <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(pwr_s.radio, 1'b1)
		bb <= 1'b0;
		wr(`SWPC_A_CTRL, 32'h3);
		`CHK(pwr_s.ana, 1'b1)
		wr(`SWPC_A_MODE, 32'h1);
		`CHK(halt, 1'b1)
		irq <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(halt, 1'b0)
		irq <= 1'b0;
		pins[5] <= 1'b1;
		wr(`SWPC_A_CMP_CFG, 32'h22c0);
		cmp <= 2'b01;
		repeat (6) @(posedge clk);
		`CHK(cirq, 1'b1)
		rd(`SWPC_A_CMP_STAT, 33'h1);
		rd(`SWPC_A_PEND, 33'h800000);
		wr(`SWPC_A_CMP_CFG, 32'h2200);
		wr(`SWPC_A_PEND, 32'hffffffff);
		`CHK(cirq, 1'b0)
		cmp <= 2'b10;
		repeat (6) @(posedge clk);
		rd(`SWPC_A_CMP_STAT, 33'h1);
		rd(`SWPC_A_PEND, 33'h0);
		wr(`SWPC_A_PIN_EN, 32'h20);
		wr(`SWPC_A_CMP_CFG, 32'h14);
		hfs <= 1'b0;
		wr(`SWPC_A_MODE, 32'h2);
		`CHK({pwr_s.dig, pwr_s.ana, pwr_s.ram}, 3'b001)
		`CHK({hold, hiz, crst_b}, 3'b110)
		`CHK({ctl_s.neg_first, ctl_s.neg_second}, {SWPC_NEG_PIN, SWPC_NEG_PIN})
		pins[5] <= 1'b0;
		repeat (12) @(posedge clk);
		`CHK(crst_b, 1'b0)
		hfs <= 1'b1;
		wt(1'b0);
		`CHK(ctl_s.neg_first, SWPC_NEG_DAC)
		rd(`SWPC_A_CAUSE, 33'h80000020);
		// Pending pin event left uncleared: sleep must end straight away
		wr(`SWPC_A_MODE, 32'h2);
		`CHK(crst_b, 1'b0)
		wt(1'b0);
		wr(`SWPC_A_PEND, 32'hffffffff);
		wr(`SWPC_A_CAUSE, 32'hffffffff);
		rd(`SWPC_A_CAUSE, 33'h0);
		wr(`SWPC_A_CTRL, 32'hc);
		wr(`SWPC_A_TMR0, 32'h5);
		wr(`SWPC_A_TMR_RUN, 32'h1);
		wr(`SWPC_A_MODE, 32'h2);
		`CHK({pwr_s.lfo, pwr_s.wake_tmr, pwr_s.ram}, 3'b110)
		wt(1'b0);
		rd(`SWPC_A_CAUSE, 33'h80200000);
		wr(`SWPC_A_TMR_RUN, 32'h0);
		wr(`SWPC_A_PEND, 32'hffffffff);
		wr(`SWPC_A_CAUSE, 32'hffffffff);
		// Second comparator, falling edge with wake enable, ends sleep
		wr(`SWPC_A_CMP_CFG, 32'h1080);
		wr(`SWPC_A_MODE, 32'h2);
		cmp <= 2'b00;
		wt(1'b0);
		rd(`SWPC_A_CAUSE, 33'h81000000);
		wr(`SWPC_A_PIN_POL, 32'h20);
		wr(`SWPC_A_MODE, 32'h3);
		`CHK({pwr_s.dig, pwr_s.ana, pwr_s.ram, pwr_s.lfo, pwr_s.wake_tmr}, 5'h0)
		pins[5] <= 1'b1;
		wt(1'b1);
		wt(1'b0);
		rd(`SWPC_A_CAUSE, 33'h20);
		wrap_up();
	end
endmodule : swpc_top_tb

bind swpc_top swpc_chk u_chk (
	.sys_clk_i(sys_clk_i),
	.rst_b_i(rst_b_i),
	.bb_radio_req_i(bb_radio_req_i),
	.irq_any_i(irq_any_i),
	.pwr_o(pwr_o),
	.cpu_halt_o(cpu_halt_o),
	.cpu_rst_b_o(cpu_rst_b_o),
	.pin_hold_o(pin_hold_o),
	.dac_hiz_o(dac_hiz_o),
	.chip_reset_o(chip_reset_o)
);
`default_nettype wire
